// ===== verilog/adrc_pkg.sv
// constants and types shared by the audio dynamic range compressor
package adrc_pkg;
  localparam int NCH         = 3;
  localparam int DATA_W      = 24;
  localparam int FRAC_W      = 23;
  localparam int LOG_W       = 32;
  localparam int SLOPE_W     = 26;
  localparam int COEF_W      = 26;
  localparam int WGT_W       = 24;
  localparam int MS_W        = 32;
  localparam int MS_FS       = 30;
  localparam int SQ_SHIFT    = 16;
  localparam int FIFO_DEPTH  = 8;
  localparam int LOG_MAX_EXP = 3;
  localparam int LOG_MIN_EXP = -24;
  localparam int SAMPLE_W    = NCH * DATA_W;

  localparam logic [COEF_W-1:0] COEF_UNITY = 26'h080_0000;
  localparam logic [COEF_W-1:0] COEF_MAX   = 26'h3FF_FFFF;
  localparam logic [WGT_W-1:0]  WGT_ONE    = 24'h80_0000;
  localparam logic [LOG_W-1:0]  HEADROOM   = 32'h0200_0000;
  localparam logic [LOG_W-1:0]  LOG_FLOOR  = 32'h8000_0000;
  localparam logic [DATA_W-1:0] SAMP_MAX   = 24'h7F_FFFF;
  localparam logic [DATA_W-1:0] SAMP_MIN   = 24'h80_0000;
  localparam logic [1:0]        EN_RESET   = 2'h0;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_EST,
    ST_LOG,
    ST_GAIN,
    ST_SMOOTH,
    ST_MIX
  } adrc_state_t;
endpackage

// ===== verilog/adrc_stream_if.sv
// valid/ready sample stream between compressor modules
`timescale 1ns/10ps
interface adrc_stream_if #(parameter int W = 72);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ===== verilog/adrc_fifo.sv
// sample fifo with registered ready and honest full/empty
`timescale 1ns/10ps
module adrc_fifo #(
  parameter int W     = 72,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic   clk,
  input wire logic   rst_n,
  // streams
  adrc_stream_if.snk wr,
  adrc_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("adrc_fifo depth must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
    logic                    rdy;
  } adrc_fifo_t;

  adrc_fifo_t r;
  adrc_fifo_t next_r;
  logic       push;
  logic       pop;

  assign push     = wr.valid && r.rdy;
  assign pop      = rd.ready && (r.cnt != '0);
  assign wr.ready = r.rdy;
  assign rd.valid = (r.cnt != '0);
  assign rd.data  = r.mem[r.rptr];

  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wptr] = wr.data;
      next_r.wptr        = r.wptr + 1'b1;
    end
    if (pop) begin
      next_r.rptr = r.rptr + 1'b1;
    end
    next_r.cnt = r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    next_r.rdy = (next_r.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r     <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule // adrc_fifo

// ===== verilog/adrc_top.sv
// audio dynamic range compressor: level estimate, log gain, smoothing, mixer
//
// Summary of operation
// - smoothed 3.23 coefficient scales the audio
// - per-channel level, largest in each band drives that band's gain
// - one averaging weight for every channel estimator
// - log of level, threshold test, target coefficient
// - attack weight on cuts, release weight on boosts
// - mixer multiplies samples by the coefficient
// - slope acts only above threshold
// - enable bit 0 first, bit 1 second
// - two independent threshold, offset, slope sets
// - thresholds are 32-bit 9.23 values
// - slopes are 26-bit 3.23 values
// - full scale is zero, lower levels negative
// - signed offset sets gain at threshold
// - host writes all settings via configuration
// - DUAL_BAND set: last channel takes the second gain
`timescale 1ns/10ps
module adrc_top
  import adrc_pkg::*;
#(
  parameter int DUAL_BAND    = 1,
  parameter int FIFO_DEPTH_P = FIFO_DEPTH
) (
  // clock and reset
  input  logic                REF_CLK,
  input  logic                RST_N,
  // audio in
  input  logic                IN_VALID,
  input  logic [SAMPLE_W-1:0] IN_DATA,
  output logic                IN_READY,
  // audio out
  output logic                OUT_VALID,
  output logic [SAMPLE_W-1:0] OUT_DATA,
  // configuration from the i2c register side
  input  logic [1:0]          ENABLE,
  input  logic [LOG_W-1:0]    FIRST_THRESHOLD,
  input  logic [LOG_W-1:0]    SECOND_THRESHOLD,
  input  logic [LOG_W-1:0]    FIRST_OFFSET,
  input  logic [LOG_W-1:0]    SECOND_OFFSET,
  input  logic [SLOPE_W-1:0]  FIRST_SLOPE,
  input  logic [SLOPE_W-1:0]  SECOND_SLOPE,
  input  logic [WGT_W-1:0]    LEVEL_AVERAGE_WEIGHT,
  input  logic [WGT_W-1:0]    ATTACK_WEIGHT,
  input  logic [WGT_W-1:0]    RELEASE_WEIGHT,
  // status
  output logic [COEF_W-1:0]   FIRST_GAIN,
  output logic [COEF_W-1:0]   SECOND_GAIN
);

  if (DUAL_BAND != 0 && DUAL_BAND != 1) begin : g_chk
    $error("adrc_top DUAL_BAND must be 0 or 1");
  end

  //----------------------------------------------------------------------
  // state
  //----------------------------------------------------------------------
  typedef struct packed {
    adrc_state_t                  st;
    logic [1:0]                   en;
    logic [1:0][LOG_W-1:0]        thr;
    logic [1:0][LOG_W-1:0]        off;
    logic [1:0][SLOPE_W-1:0]      slope;
    logic [WGT_W-1:0]             avw;
    logic [WGT_W-1:0]             atw;
    logic [WGT_W-1:0]             rlw;
    logic [NCH-1:0][DATA_W-1:0]   samp;
    logic [NCH-1:0][MS_W-1:0]     ms;
    logic [1:0][LOG_W-1:0]        lvl;
    logic [1:0][LOG_W-1:0]        glog;
    logic [1:0][COEF_W-1:0]       tgt;
    logic [1:0][COEF_W-1:0]       coef;
    logic                         out_valid;
    logic [NCH-1:0][DATA_W-1:0]   out;
  } adrc_core_t;

  adrc_core_t r;
  adrc_core_t next_r;

  adrc_stream_if #(.W(SAMPLE_W)) in_if ();
  adrc_stream_if #(.W(SAMPLE_W)) rd_if ();

  assign in_if.valid = IN_VALID;
  assign in_if.data  = IN_DATA;
  assign rd_if.ready = (r.st == ST_IDLE);

  adrc_fifo #(
    .W     (SAMPLE_W),
    .DEPTH (FIFO_DEPTH_P)
  ) u_fifo (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .wr    (in_if),
    .rd    (rd_if)
  );

  //----------------------------------------------------------------------
  // arithmetic
  //----------------------------------------------------------------------
  function automatic int band_of(input int c);
    return (DUAL_BAND != 0 && c == NCH - 1) ? 1 : 0;
  endfunction

  function automatic logic [WGT_W-1:0] wcl(input logic [WGT_W-1:0] w);
    return (w > WGT_ONE) ? WGT_ONE : w;
  endfunction

  // old + w * (new - old), w in 1.23
  function automatic longint wmix(input longint o, input longint n, input logic [WGT_W-1:0] w);
    return o + (((n - o) * longint'(w)) >>> FRAC_W);
  endfunction

  function automatic logic [MS_W-1:0] sq(input logic [DATA_W-1:0] x);
    longint s;
    s = longint'($signed(x));
    return MS_W'((s * s) >>> SQ_SHIFT);
  endfunction

  // log2 of rms in 9.23, full scale reads zero
  function automatic logic [LOG_W-1:0] hlog(input logic [MS_W-1:0] v);
    int               p;
    logic [MS_W-1:0]  n;
    logic [LOG_W-1:0] l;
    p = 0;
    l = LOG_FLOOR;
    for (int i = 0; i < MS_W; i++) begin
      if (v[i]) p = i;
    end
    n = v << (MS_W - 1 - p);
    if (v != '0) l = {9'(p - MS_FS), n[MS_W-2 -: FRAC_W]};
    return {l[LOG_W-1], l[LOG_W-1:1]};
  endfunction

  // 2^g from 9.23 log to 3.23 linear
  function automatic logic [COEF_W-1:0] ex2(input logic [LOG_W-1:0] g);
    int                ie;
    logic [2*COEF_W-1:0] m;
    logic [COEF_W-1:0] c;
    ie = int'($signed(g[LOG_W-1:FRAC_W]));
    m  = {(2*COEF_W-FRAC_W)'(1), g[FRAC_W-1:0]};
    if (ie >= LOG_MAX_EXP) c = COEF_MAX;
    else if (ie < LOG_MIN_EXP) c = '0;
    else if (ie >= 0) c = COEF_W'(m << ie);
    else c = COEF_W'(m >> (-ie));
    return c;
  endfunction

  function automatic logic [DATA_W-1:0] scale(input logic [DATA_W-1:0] x, input logic [COEF_W-1:0] c);
    longint v;
    v = (longint'($signed(x)) * longint'(c)) >>> FRAC_W;
    if (v > longint'($signed(SAMP_MAX))) return SAMP_MAX;
    if (v < longint'($signed(SAMP_MIN))) return SAMP_MIN;
    return DATA_W'(v);
  endfunction

  //----------------------------------------------------------------------
  // sample sequencer
  //----------------------------------------------------------------------
  always_comb begin
    logic [MS_W-1:0] pk;
    longint          d;
    logic [LOG_W-1:0] g;
    pk = '0;
    d  = 0;
    g  = '0;
    next_r = r;
    next_r.out_valid = 1'b0;
    case (r.st)
      ST_IDLE: begin
        if (rd_if.valid) begin
          // settings sampled only here, once per sample
          next_r.samp     = rd_if.data;
          next_r.en       = ENABLE;
          next_r.thr[0]   = FIRST_THRESHOLD + HEADROOM;
          next_r.thr[1]   = SECOND_THRESHOLD + HEADROOM;
          next_r.off[0]   = FIRST_OFFSET;
          next_r.off[1]   = SECOND_OFFSET;
          next_r.slope[0] = FIRST_SLOPE;
          next_r.slope[1] = SECOND_SLOPE;
          next_r.avw      = wcl(LEVEL_AVERAGE_WEIGHT);
          next_r.atw      = wcl(ATTACK_WEIGHT);
          next_r.rlw      = wcl(RELEASE_WEIGHT);
          next_r.st       = ST_EST;
        end
      end
      ST_EST: begin
        for (int c = 0; c < NCH; c++) begin
          next_r.ms[c] = MS_W'(wmix(longint'(r.ms[c]), longint'(sq(r.samp[c])), r.avw));
        end
        next_r.st = ST_LOG;
      end
      ST_LOG: begin
        for (int b = 0; b < 2; b++) begin
          pk = '0;
          for (int c = 0; c < NCH; c++) begin
            if (band_of(c) == b && r.ms[c] > pk) pk = r.ms[c];
          end
          next_r.lvl[b] = hlog(pk);
        end
        next_r.st = ST_GAIN;
      end
      ST_GAIN: begin
        for (int b = 0; b < 2; b++) begin
          d = 0;
          // negative programmed threshold keeps this region sane
          if ($signed(r.lvl[b]) > $signed(r.thr[b])) begin
            d = (longint'($signed(r.slope[b])) *
                 (longint'($signed(r.lvl[b])) - longint'($signed(r.thr[b])))) >>> FRAC_W;
          end
          g = LOG_W'(longint'($signed(r.off[b])) + d);
          next_r.glog[b] = g;
          next_r.tgt[b]  = ex2(g);
        end
        next_r.st = ST_SMOOTH;
      end
      ST_SMOOTH: begin
        for (int b = 0; b < 2; b++) begin
          if (!r.en[b]) begin
            next_r.coef[b] = COEF_UNITY;
          end else if (r.tgt[b] < r.coef[b]) begin
            next_r.coef[b] = COEF_W'(wmix(longint'(r.coef[b]), longint'(r.tgt[b]), r.atw));
          end else begin
            next_r.coef[b] = COEF_W'(wmix(longint'(r.coef[b]), longint'(r.tgt[b]), r.rlw));
          end
        end
        next_r.st = ST_MIX;
      end
      ST_MIX: begin
        for (int c = 0; c < NCH; c++) begin
          if (r.en[band_of(c)]) begin
            next_r.out[c] = scale(r.samp[c], r.coef[band_of(c)]);
          end else begin
            next_r.out[c] = r.samp[c];
          end
        end
        next_r.out_valid = 1'b1;
        next_r.st        = ST_IDLE;
      end
      default: begin
        next_r.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      r      <= '0;
      r.en   <= EN_RESET;
      r.coef <= {COEF_UNITY, COEF_UNITY};
    end else begin
      r <= next_r;
    end
  end

  //----------------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------------
  assign IN_READY    = in_if.ready;
  assign OUT_VALID   = r.out_valid;
  assign OUT_DATA    = r.out;
  assign FIRST_GAIN  = r.coef[0];
  assign SECOND_GAIN = r.coef[1];

  //----------------------------------------------------------------------
  // assertions
  //----------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_N);

  property p_reset_unity;
    $rose(RST_N) |-> (r.coef[0] == COEF_UNITY) && (r.coef[1] == COEF_UNITY) && (r.en == EN_RESET);
  endproperty
  a_reset_unity: assert property (p_reset_unity) else $error("gain not unity after reset");

  property p_param_hold;
    (r.st != ST_IDLE) |=> $stable(r.thr) && $stable(r.en) && $stable(r.slope) && $stable(r.off);
  endproperty
  a_param_hold: assert property (p_param_hold) else $error("settings changed mid sample");

  property p_avg_hold;
    (r.st == ST_EST && r.avw == '0) |=> (r.ms == $past(r.ms));
  endproperty
  a_avg_hold: assert property (p_avg_hold) else $error("estimate moved with zero weight");

  // estimates only move in the estimate stage, so they still hold here
  property p_peak;
    (r.st == ST_LOG) |=> ($signed(r.lvl[0]) >= $signed(hlog(r.ms[0]))) &&
                         ($signed(r.lvl[0]) >= $signed(hlog(r.ms[1])));
  endproperty
  a_peak: assert property (p_peak) else $error("level below a channel estimate");

  property p_full_scale;
    (r.st == ST_GAIN) |-> ($signed(r.lvl[0]) <= $signed(32'h0000_0000));
  endproperty
  a_full_scale: assert property (p_full_scale) else $error("level above full scale");

  property p_below_thr;
    (r.st == ST_SMOOTH && !($signed(r.lvl[0]) > $signed(r.thr[0]))) |-> (r.glog[0] == r.off[0]);
  endproperty
  a_below_thr: assert property (p_below_thr) else $error("slope applied below threshold");

  property p_attack;
    (r.st == ST_SMOOTH && r.en[0] && r.tgt[0] < r.coef[0]) |=>
      (r.coef[0] <= $past(r.coef[0])) && (r.coef[0] >= $past(r.tgt[0]));
  endproperty
  a_attack: assert property (p_attack) else $error("cut overshoots target");

  property p_release;
    (r.st == ST_SMOOTH && r.en[0] && r.tgt[0] >= r.coef[0]) |=>
      (r.coef[0] >= $past(r.coef[0])) && (r.coef[0] <= $past(r.tgt[0]));
  endproperty
  a_release: assert property (p_release) else $error("boost overshoots target");

  property p_disable;
    (r.st == ST_SMOOTH && !r.en[1]) |=> (r.coef[1] == COEF_UNITY);
  endproperty
  a_disable: assert property (p_disable) else $error("disabled band not unity");

  property p_mix;
    (r.st == ST_MIX && r.en[0]) |=> OUT_VALID && (OUT_DATA[DATA_W-1:0] == scale(r.samp[0], r.coef[0]))
                                     ##1 !OUT_VALID;
  endproperty
  a_mix: assert property (p_mix) else $error("mixer output wrong");

  property p_pass;
    (r.st == ST_MIX && r.en == 2'h0) |=> (OUT_DATA == $past(r.samp));
  endproperty
  a_pass: assert property (p_pass) else $error("disabled path not transparent");

  c_compress: cover property (r.st == ST_SMOOTH && r.en[0] && $signed(r.lvl[0]) > $signed(r.thr[0]));
  c_attack:   cover property (r.st == ST_SMOOTH && r.en[0] && r.tgt[0] < r.coef[0]);
  c_release:  cover property (r.st == ST_SMOOTH && r.en[0] && r.tgt[0] > r.coef[0]);
  c_full:     cover property (!IN_READY);
  c_avg_hold: cover property (r.st == ST_EST && r.avw == '0);
endmodule // adrc_top

// ===== dv/adrc_src_model.sv
// upstream sample source that holds each frame until the compressor takes it
`timescale 1ns/10ps
module adrc_src_model
  import adrc_pkg::*;
(
  // clock
  input  wire logic              clk,
  // stream toward the compressor
  input  wire logic              in_ready,
  output logic                   in_valid,
  output logic [SAMPLE_W-1:0]    in_data
);
  initial begin
    in_valid = 1'b0;
    in_data  = '0;
  end

  // frame held, valid high, until a rising edge samples ready high
  // ready is a flop, so its value at the falling edge is what the next rising edge sees
  task automatic send(input logic [SAMPLE_W-1:0] d);
    @(negedge clk);
    in_valid = 1'b1;
    in_data  = d;
    while (in_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  // released data lines show the inverse of the last frame
  task automatic idle();
    @(negedge clk);
    in_valid = 1'b0;
    in_data  = ~in_data;
  endtask
endmodule // adrc_src_model

// ===== dv/tb_top.sv
// self-checking bench for the audio dynamic range compressor
`timescale 1ns/10ps
module tb_top;
  import adrc_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [LOG_W-1:0]   NEG_ONE  = 32'hFF80_0000;
  localparam logic [LOG_W-1:0]   POS_ONE  = 32'h0080_0000;
  localparam logic [LOG_W-1:0]   THR_LOW  = 32'hF600_0000;
  localparam logic [SLOPE_W-1:0] K_HALF   = 26'h3C0_0000;
  logic                REF_CLK, RST_N, IN_VALID, IN_READY, OUT_VALID;
  logic [SAMPLE_W-1:0] IN_DATA, OUT_DATA;
  logic [1:0]          ENABLE;
  logic [LOG_W-1:0]    FIRST_THRESHOLD, SECOND_THRESHOLD, FIRST_OFFSET, SECOND_OFFSET;
  logic [SLOPE_W-1:0]  FIRST_SLOPE, SECOND_SLOPE;
  logic [WGT_W-1:0]    LEVEL_AVERAGE_WEIGHT, ATTACK_WEIGHT, RELEASE_WEIGHT;
  logic [COEF_W-1:0]   FIRST_GAIN, SECOND_GAIN;
  int                  error_cnt, compares, ready_lo;
  logic [SAMPLE_W-1:0] exp_q[$];
  bit                  chk_q[$];

  adrc_top dut_u (.REF_CLK(REF_CLK), .RST_N(RST_N), .IN_VALID(IN_VALID), .IN_DATA(IN_DATA),
    .IN_READY(IN_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA), .ENABLE(ENABLE),
    .FIRST_THRESHOLD(FIRST_THRESHOLD), .SECOND_THRESHOLD(SECOND_THRESHOLD),
    .FIRST_OFFSET(FIRST_OFFSET), .SECOND_OFFSET(SECOND_OFFSET), .FIRST_SLOPE(FIRST_SLOPE),
    .SECOND_SLOPE(SECOND_SLOPE), .LEVEL_AVERAGE_WEIGHT(LEVEL_AVERAGE_WEIGHT),
    .ATTACK_WEIGHT(ATTACK_WEIGHT), .RELEASE_WEIGHT(RELEASE_WEIGHT),
    .FIRST_GAIN(FIRST_GAIN), .SECOND_GAIN(SECOND_GAIN));
  adrc_src_model src_u (.clk(REF_CLK), .in_ready(IN_READY), .in_valid(IN_VALID), .in_data(IN_DATA));

  initial begin
    REF_CLK = 1'b0;
    forever #5 REF_CLK = ~REF_CLK;
  end
  // ----------------------------------------
  // compare and closing tasks
  // ----------------------------------------
  task automatic cmp_data(string nm, logic [SAMPLE_W-1:0] e, logic [SAMPLE_W-1:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic cmp_gain(string nm, logic [COEF_W-1:0] e, logic [COEF_W-1:0] s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic cmp_bit(string nm, logic e, logic s);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("BAD %s exp %b got %b", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ----------------------------------------
  // expectation helpers: 0 pass, 1 halve, 2 double, 3 unchecked
  // ----------------------------------------
  function automatic logic [DATA_W-1:0] xf(logic [DATA_W-1:0] x, int m);
    logic signed [DATA_W:0] t;
    t = {x[DATA_W-1], x};
    if (m == 1) return DATA_W'(t >>> 1);
    if (m != 2) return x;
    t = t <<< 1;
    if (t > $signed({1'b0, SAMP_MAX})) return SAMP_MAX;
    if (t < $signed({1'b1, SAMP_MIN})) return SAMP_MIN;
    return DATA_W'(t);
  endfunction
  task automatic push_send(logic [SAMPLE_W-1:0] d, int m1, int m2);
    exp_q.push_back({xf(d[71:48], m2), xf(d[47:24], m1), xf(d[23:0], m1)});
    chk_q.push_back(m1 != 3);
    src_u.send(d);
  endtask
  task automatic burst(int n, int m1, int m2);
    logic [31:0] r[3];
    repeat (n) begin
      foreach (r[i]) r[i] = $urandom;
      push_send({{2{r[2][22]}}, r[2][21:1], 1'b0, {2{r[1][22]}}, r[1][21:1], 1'b0,
                 {2{r[0][22]}}, r[0][21:1], 1'b0}, m1, m2);
    end
  endtask
  task automatic drain();
    int n;
    n = 0;
    src_u.idle();
    while (exp_q.size() != 0 && n < 2000) begin
      @(negedge REF_CLK);
      n++;
    end
    if (exp_q.size() != 0) begin
      error_cnt++;
      $display("BAD drain_left exp %0d got %0d", 0, exp_q.size());
    end
    repeat (4) @(negedge REF_CLK);
  endtask
  // host side programming between frames
  task automatic set_cfg(logic [1:0] en, logic [LOG_W-1:0] o1, o2, logic [WGT_W-1:0] att, rel);
    @(negedge REF_CLK);
    ENABLE         = en;
    FIRST_OFFSET   = o1;
    SECOND_OFFSET  = o2;
    ATTACK_WEIGHT  = att;
    RELEASE_WEIGHT = rel;
  endtask
  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(negedge REF_CLK) begin
    if (RST_N === 1'b1 && IN_READY === 1'b0) ready_lo++;
    if (RST_N === 1'b1 && OUT_VALID === 1'b1) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("BAD out_valid exp 0 got 1");
      end else if (chk_q.pop_front())
        cmp_data("out_data", exp_q.pop_front(), OUT_DATA);
      else
        void'(exp_q.pop_front());
    end
  end

  initial begin
    repeat (20000) @(posedge REF_CLK);
    error_cnt++;
    $display("BAD watchdog exp done got hang");
    summarize();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    RST_N = 1'b0; ENABLE = 2'h0; LEVEL_AVERAGE_WEIGHT = WGT_ONE;
    FIRST_THRESHOLD  = NEG_ONE;
    SECOND_THRESHOLD = NEG_ONE;
    FIRST_SLOPE = K_HALF; SECOND_SLOPE = K_HALF;
    FIRST_OFFSET = '0; SECOND_OFFSET = '0; ATTACK_WEIGHT = WGT_ONE; RELEASE_WEIGHT = WGT_ONE;
    void'($urandom(32'h68887a96));
    repeat (8) @(negedge REF_CLK);
    cmp_bit("ready_rst", 1'b1, IN_READY);
    cmp_bit("valid_rst", 1'b0, OUT_VALID);
    cmp_gain("gain1_rst", COEF_UNITY, FIRST_GAIN);
    cmp_gain("gain2_rst", COEF_UNITY, SECOND_GAIN);
    RST_N = 1'b1;
    burst(12, 0, 0);
    drain();
    cmp_bit("fifo_refused", 1'b1, 1'(ready_lo > 0));
    set_cfg(2'b01, NEG_ONE, '0, WGT_ONE, WGT_ONE);
    burst(4, 1, 0);
    drain();
    cmp_gain("gain1_cut", 26'h040_0000, FIRST_GAIN);
    cmp_gain("gain2_off", COEF_UNITY, SECOND_GAIN);
    set_cfg(2'b10, '0, NEG_ONE, WGT_ONE, WGT_ONE);
    burst(4, 0, 1);
    drain();
    cmp_gain("gain2_cut", 26'h040_0000, SECOND_GAIN);
    cmp_gain("gain1_off", COEF_UNITY, FIRST_GAIN);
    set_cfg(2'b11, POS_ONE, POS_ONE, '0, WGT_ONE);
    burst(3, 2, 2);
    drain();
    cmp_gain("gain1_boost", 26'h100_0000, FIRST_GAIN);
    cmp_gain("gain2_boost", 26'h100_0000, SECOND_GAIN);
    set_cfg(2'b11, NEG_ONE, NEG_ONE, '0, WGT_ONE);
    burst(3, 2, 2);
    push_send({24'h10_0000, 24'hA0_0000, 24'h60_0000}, 2, 2);
    drain();
    cmp_gain("gain1_hold", 26'h100_0000, FIRST_GAIN);
    FIRST_THRESHOLD = THR_LOW;
    set_cfg(2'b01, '0, '0, WGT_ONE, WGT_ONE);
    repeat (3) push_send({24'h00_0000, 24'h40_0000, 24'h00_0000}, 3, 3);
    drain();
    cmp_bit("gain1_comp", 1'b1, FIRST_GAIN < COEF_UNITY);
    FIRST_SLOPE = '0;
    repeat (3) push_send({24'h00_0000, 24'h40_0000, 24'h00_0000}, 3, 3);
    drain();
    cmp_gain("gain1_flat", COEF_UNITY, FIRST_GAIN);
    // zero weight: estimate keeps the loud level although silence arrives
    LEVEL_AVERAGE_WEIGHT = '0;
    FIRST_SLOPE = K_HALF;
    repeat (2) push_send('0, 0, 0);
    drain();
    cmp_bit("gain1_avg_hold", 1'b1, FIRST_GAIN < COEF_UNITY);
    summarize();
  end
endmodule // tb_top
